// >>> rtl/mms_pkg.sv
package mms_pkg;

  // Frame field widths
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned OP_W = 2;

  // Frame layout constants
  localparam logic [5:0] PRE_ONES = 6'h20;
  localparam logic [5:0] OP_BITS = 6'h02;
  localparam logic [5:0] ADDR_BITS = 6'h05;
  localparam logic [5:0] DATA_BITS = 6'h10;
  localparam logic [OP_W-1:0] OP_WRITE = 2'h1;
  localparam logic [OP_W-1:0] OP_READ = 2'h2;
  localparam logic [ADDR_W-1:0] BCAST_ADDR = 5'h00;
  localparam logic [ADDR_W-1:0] VENDOR_BASE = 5'h10;

  // Local control word, register 0, reset value
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 5'h00;
  localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;

  // Link timing: fastest management clock, and the fewest core cycles per half period
  localparam int unsigned CORE_CLK_KHZ = 100000;
  localparam int unsigned MDC_MAX_KHZ = 2500;
  localparam int unsigned MDC_HALF_CYCLES = CORE_CLK_KHZ / (2 * MDC_MAX_KHZ);

  // Frame receiver states
  typedef enum logic [2:0] {
    MMS_PRE = 3'b000,
    MMS_ST = 3'b001,
    MMS_OP = 3'b010,
    MMS_PHY = 3'b011,
    MMS_REG = 3'b100,
    MMS_TA = 3'b101,
    MMS_WDATA = 3'b110,
    MMS_RDATA = 3'b111
  } mms_state_t;

  // Register write handed to the core
  typedef struct packed {
    logic valid;
    logic bcast;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } mms_wr_t;

endpackage : mms_pkg

// >>> rtl/mms_sync2.sv
`timescale 1ns/1ns

// Two-stage synchroniser; only stage two leaves the module
module mms_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // Stage one is read by stage two alone
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : mms_sync2

// >>> rtl/mms_slave.sv
`timescale 1ns/1ns

// Contract
// - A frame that addresses this device is always answered; the code ignores opcodes 00 and 11, and every frame when MGMT_EN is 0.
// - Two wires: master clock and one shared data line.
// - Frame has type, address and data fields, timed by management clock.
// - Opcode 01 stores sixteen data bits into the addressed register.
// - Opcode 10 takes the line at turnaround and drives sixteen register bits.
// - Five-bit physical address selects one of 32 slaves.
// - Physical address 0 is accepted besides the own address.
// - Write to physical address 0 is a broadcast command.
// - Five-bit register address selects one of 32 registers.
// - Registers 0-15 standard, 16-31 vendor specific.
// - Management port optional; otherwise a configuration vector is used.
// - Undefined registers read zero and ignore writes.
// - Data line appears as separate input, output and enable.
module mms_slave #(
  parameter bit MGMT_EN = 1'b1,
  parameter logic [31:0] DEFINED_MASK = 32'h0001_81FF
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic [mms_pkg::ADDR_W-1:0] phy_addr,
  input wire logic [mms_pkg::DATA_W-1:0] cfg_vector,
  output logic [mms_pkg::ADDR_W-1:0] rd_addr,
  input wire logic [mms_pkg::DATA_W-1:0] rd_data,
  output mms_pkg::mms_wr_t wr,
  output logic [mms_pkg::DATA_W-1:0] ctrl_word,
  output logic frame_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling

  logic [1:0] pins_sync;
  logic mdc_prev;
  wire mdc_s = pins_sync[1];
  wire mdio_s = pins_sync[0];
  wire mdc_rise = mdc_s & ~mdc_prev;
  wire bit_in = (MGMT_EN != 1'b0) && mdc_rise;

  // Clock and data cross into the core domain together
  mms_sync2 #(
    .WIDTH(2)
  ) u_sync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .async_in({mdc, mdio_in}),
    .sync_out(pins_sync)
  );

  // Previous synced clock for edge detection
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mdc_prev <= 1'b0;
    end else if (clk_en) begin
      mdc_prev <= mdc_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame decode

  mms_pkg::mms_state_t state;
  logic [5:0] cnt;
  logic [5:0] ones;
  logic [mms_pkg::DATA_W-1:0] shreg;
  logic [mms_pkg::OP_W-1:0] opcode;
  logic [mms_pkg::ADDR_W-1:0] phy;
  logic [mms_pkg::DATA_W-1:0] rd_shift;

  wire [mms_pkg::DATA_W-1:0] sh_next = {shreg[mms_pkg::DATA_W-2:0], mdio_s};
  wire [5:0] cnt_inc = cnt + 6'h01;
  wire [mms_pkg::ADDR_W-1:0] phy_now = sh_next[mms_pkg::ADDR_W-1:0];
  wire [mms_pkg::ADDR_W-1:0] reg_now = sh_next[mms_pkg::ADDR_W-1:0];
  // Own address or broadcast; phy_addr is assumed 1..31 by configuration
  wire phy_hit = (phy == phy_addr) || (phy == mms_pkg::BCAST_ADDR);
  wire is_write = (opcode == mms_pkg::OP_WRITE);
  wire is_read = (opcode == mms_pkg::OP_READ);
  wire reg_defined = DEFINED_MASK[rd_addr];
  wire [mms_pkg::DATA_W-1:0] rd_word = reg_defined ? rd_data : '0;
  wire wr_done = (state == mms_pkg::MMS_WDATA) && bit_in && (cnt_inc == mms_pkg::DATA_BITS);
  wire wr_allowed = wr_done && reg_defined;

  assign frame_busy = (state != mms_pkg::MMS_PRE);

  // Receiver sequencing, one step per rising management clock edge; idles
  // until the master begins a preamble, never starts anything itself
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= mms_pkg::MMS_PRE;
      cnt <= 6'h00;
      ones <= 6'h00;
      shreg <= '0;
      opcode <= '0;
      phy <= '0;
      rd_addr <= '0;
    end else if (clk_en && bit_in) begin
      shreg <= sh_next;
      cnt <= cnt_inc;
      unique case (state)
        mms_pkg::MMS_PRE: begin
          if (mdio_s) begin
            ones <= (ones == mms_pkg::PRE_ONES) ? ones : ones + 6'h01;
          end else begin
            ones <= 6'h00;
            if (ones == mms_pkg::PRE_ONES) state <= mms_pkg::MMS_ST;
          end
        end
        mms_pkg::MMS_ST: begin
          cnt <= 6'h00;
          state <= mdio_s ? mms_pkg::MMS_OP : mms_pkg::MMS_PRE;
        end
        mms_pkg::MMS_OP: begin
          if (cnt_inc == mms_pkg::OP_BITS) begin
            opcode <= sh_next[mms_pkg::OP_W-1:0];
            cnt <= 6'h00;
            state <= mms_pkg::MMS_PHY;
          end
        end
        mms_pkg::MMS_PHY: begin
          if (cnt_inc == mms_pkg::ADDR_BITS) begin
            phy <= phy_now;
            cnt <= 6'h00;
            state <= mms_pkg::MMS_REG;
          end
        end
        mms_pkg::MMS_REG: begin
          if (cnt_inc == mms_pkg::ADDR_BITS) begin
            rd_addr <= reg_now;
            cnt <= 6'h00;
            // Frames for others or with bad opcodes go back to hunting
            state <= (phy_hit && (is_write || is_read)) ? mms_pkg::MMS_TA : mms_pkg::MMS_PRE;
          end
        end
        mms_pkg::MMS_TA: begin
          if (cnt_inc == mms_pkg::OP_BITS) begin
            cnt <= 6'h00;
            state <= is_read ? mms_pkg::MMS_RDATA : mms_pkg::MMS_WDATA;
          end
        end
        mms_pkg::MMS_WDATA: begin
          if (cnt_inc == mms_pkg::DATA_BITS) state <= mms_pkg::MMS_PRE;
        end
        mms_pkg::MMS_RDATA: begin
          if (cnt_inc == mms_pkg::DATA_BITS) state <= mms_pkg::MMS_PRE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read driver

  wire ta_first = (state == mms_pkg::MMS_TA) && is_read && (cnt == 6'h00);
  wire rd_step = (state == mms_pkg::MMS_RDATA) && (cnt_inc != mms_pkg::DATA_BITS);

  // Line changes only on the rising edge, so the master samples a settled bit
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mdio_oe <= 1'b0;
      mdio_out <= 1'b0;
      rd_shift <= '0;
    end else if (clk_en && bit_in) begin
      if (ta_first) begin
        mdio_oe <= 1'b1;
        mdio_out <= 1'b0;
        rd_shift <= rd_word;
      end else if ((state == mms_pkg::MMS_TA) && is_read) begin
        mdio_out <= rd_shift[mms_pkg::DATA_W-1];
        rd_shift <= {rd_shift[mms_pkg::DATA_W-2:0], 1'b0};
      end else if (rd_step) begin
        mdio_out <= rd_shift[mms_pkg::DATA_W-1];
        rd_shift <= {rd_shift[mms_pkg::DATA_W-2:0], 1'b0};
      end else begin
        mdio_oe <= 1'b0;
        mdio_out <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write port and local control word

  logic [mms_pkg::DATA_W-1:0] ctrl_reg;
  assign ctrl_word = (MGMT_EN != 1'b0) ? ctrl_reg : cfg_vector;

  // One-cycle write pulse; broadcast flagged so the core can obey it
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr <= '0;
      ctrl_reg <= mms_pkg::CTRL_RESET;
    end else if (clk_en) begin
      wr.valid <= wr_allowed;
      if (wr_allowed) begin
        wr.addr <= rd_addr;
        wr.data <= sh_next;
        wr.bcast <= (phy == mms_pkg::BCAST_ADDR);
        if (rd_addr == mms_pkg::CTRL_ADDR) ctrl_reg <= sh_next;
      end
    end
  end

endmodule : mms_slave

// >>> dv/mms_mdio_master.sv
`timescale 1ns/1ns

// Management master model: clock stands low outside frames, line released between them
module mms_mdio_master (
  output logic mdc,
  output logic m_oe,
  output logic m_d,
  input wire logic mdio
);
  initial begin
    mdc = 1'b0;
    m_oe = 1'b0;
    m_d = 1'b1;
  end

  // One bit: data set while the clock is low, line sampled just before the rise
  task automatic bit_io(input logic b, input logic drv, output logic s);
    m_oe = drv;
    m_d = b;
    #40 s = mdio;
    mdc = 1'b1; // 80 ns period runs faster than the 400 ns clock limit
    #40 mdc = 1'b0;
  endtask : bit_io

  // Whole frame MSB first; a read lets go of the line from turnaround on
  task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [1:0] ta, output logic [15:0] rd);
    logic [63:0] f;
    logic s;
    f = {32'hFFFF_FFFF, 2'h1, op, phy, ra, 2'h2, wd};
    for (int i = 63; i >= 0; i--) begin
      bit_io(f[i], !(op == 2'h2 && i < 18), s);
      if (i == 17 || i == 16) ta[i-16] = s;
      if (i < 16) rd[i] = s;
    end
    m_oe = 1'b0;
  endtask : xfer
endmodule : mms_mdio_master

// >>> dv/mms_slave_sva.sv
`timescale 1ns/1ns

module mms_slave_sva #(
  parameter bit MGMT_EN = 1'b1,
  parameter logic [31:0] DEFINED_MASK = 32'h0001_81FF
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic mdc,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  input wire logic [mms_pkg::ADDR_W-1:0] rd_addr,
  input wire mms_pkg::mms_wr_t wr,
  input wire logic [mms_pkg::DATA_W-1:0] ctrl_word,
  input wire logic frame_busy
);
  logic mdc_q;
  logic [4:0] rise_n;
  ////////////////////////////////////////
  // Clock rises seen while the slave drives; raw sampling runs ahead of the design's synchroniser
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mdc_q <= 1'b0;
      rise_n <= 5'h00;
    end else begin
      mdc_q <= mdc;
      rise_n <= !mdio_oe ? 5'h00 : rise_n + 5'(mdc & !mdc_q);
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  wr_pulse_a: assert property (wr.valid |=> !wr.valid) else $error("write pulse too long");
  wr_mask_a: assert property (wr.valid |-> DEFINED_MASK[wr.addr]) else $error("write to undefined reg");
  ctrl_load_a: assert property (MGMT_EN && wr.valid && wr.addr == mms_pkg::CTRL_ADDR |-> ##[0:1]
    ctrl_word == wr.data) else $error("control word not loaded");
  oe_timing_a: assert property ($changed(mdio_oe) |-> $past(mdc) && $past(mdc, 2))
    else $error("enable moved away from clock rise");
  out_timing_a: assert property (mdio_oe && $changed(mdio_out) |-> $past(mdc) && $past(mdc, 2))
    else $error("data moved away from clock rise");
  ta_zero_a: assert property ($rose(mdio_oe) |-> !mdio_out) else $error("turnaround not zero");
  drive_len_a: assert property ($fell(mdio_oe) |-> rise_n == 5'h11) else $error("drive length wrong");
  addr_hold_a: assert property (mdio_oe |-> $stable(rd_addr)) else $error("reg address moved in read");
  busy_drive_a: assert property (mdio_oe |-> frame_busy) else $error("driving outside a frame");
  cover property (wr.valid && wr.bcast);
  cover property (wr.valid && !wr.bcast);
  cover property ($fell(mdio_oe));
endmodule : mms_slave_sva

bind mms_slave mms_slave_sva #(.MGMT_EN(MGMT_EN), .DEFINED_MASK(DEFINED_MASK)) sva_u (.core_clk(core_clk),
  .arst_n(arst_n), .mdc(mdc), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .rd_addr(rd_addr), .wr(wr),
  .ctrl_word(ctrl_word), .frame_busy(frame_busy));

// >>> dv/mms_slave_tb_top.sv
`timescale 1ns/1ns

module mms_slave_tb_top;
  logic core_clk, arst_n, clk_en, mdc, mdio_out, mdio_oe, m_oe, m_d, busy;
  logic [4:0] phy_addr, rd_addr;
  logic [15:0] cfg_vector, rd_data, ctrl_word, rd, d, e;
  logic [15:0] mem [32];
  logic [1:0] ta;
  logic [21:0] exq [$];
  mms_pkg::mms_wr_t wr;
  mms_pkg::mms_wr_t off_wr;
  logic off_oe, off_seen;
  logic [15:0] off_ctrl;
  int n_errors, compares, cyc;
  wire logic mdio = m_oe ? m_d : (mdio_oe ? mdio_out : 1'b1); // Pull-up when nobody drives
  wire logic [21:0] g = {wr.bcast, wr.addr, wr.data};

  mms_slave dut_u (.core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en), .mdc(mdc), .mdio_in(mdio),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .phy_addr(phy_addr), .cfg_vector(cfg_vector),
    .rd_addr(rd_addr), .rd_data(rd_data), .wr(wr), .ctrl_word(ctrl_word), .frame_busy(busy));
  mms_mdio_master p_u (.mdc(mdc), .m_oe(m_oe), .m_d(m_d), .mdio(mdio));

  // Build without the management port: never drives, control word follows the vector
  mms_slave #(.MGMT_EN(1'b0)) dut_off_u (.core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en), .mdc(mdc),
    .mdio_in(mdio), .mdio_out(), .mdio_oe(off_oe), .phy_addr(phy_addr), .cfg_vector(cfg_vector),
    .rd_addr(), .rd_data(rd_data), .wr(off_wr), .ctrl_word(off_ctrl), .frame_busy());

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Core register file; the timeout ceiling is about three times the planned run
  always @(posedge core_clk) begin
    rd_data <= mem[rd_addr];
    if (wr.valid === 1'b1) mem[wr.addr] <= wr.data;
    if (wr.valid === 1'b1) chk(g, exq.size() ? exq.pop_front() : ~g);
    off_seen <= off_seen | off_oe | off_wr.valid; // Sticky: any activity of the portless build
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      $display("[FAIL] %0t timeout cycles %h limit %h", $time, cyc, 20000);
      wrap_up();
    end
  end

  task automatic chk(input logic [21:0] got, input logic [21:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One frame; writes expected to land (hit) leave a note, reads compare turnaround and data
  task automatic run(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] wd,
                     input logic hit, input logic [15:0] xr);
    if (op == 2'h1 && hit) exq.push_back({phy == 5'h00, ra, wd});
    #2 p_u.xfer(op, phy, ra, wd, ta, rd);
    if (op == 2'h2) chk({4'h0, ta, rd}, {4'h0, hit ? 2'h2 : 2'h3, xr});
    repeat (10) @(posedge core_clk);
    $display("test done op %h phy %h reg %h", op, phy, ra);
  endtask : run

  task automatic wrap_up;
    if (exq.size() != 0) begin
      n_errors++;
      $display("[FAIL] %0t notes left %h exp %h", $time, exq.size(), 0);
    end
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////
  initial begin
    arst_n = 1'b0;
    clk_en = 1'b1;
    phy_addr = 5'h05; // Nonzero own address keeps clear of the broadcast slot
    cfg_vector = 16'h0000;
    off_seen = 1'b0;
    n_errors = 0;
    compares = 0;
    cyc = 0;
    for (int i = 0; i < 32; i++) mem[i] = 16'h5A5A;
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    d = 16'($urandom(32'h1649));
    d = 16'($urandom());
    e = 16'($urandom());
    cfg_vector <= 16'($urandom());
    run(2'h1, 5'h05, 5'h10, d, 1'b1, 16'h0000);
    run(2'h2, 5'h05, 5'h10, 16'h0000, 1'b1, d);
    run(2'h1, 5'h00, 5'h00, e, 1'b1, 16'h0000);
    chk({6'h00, ctrl_word}, {6'h00, e});
    // Mid-run reset returns the local control word to its reset value
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk({6'h00, ctrl_word}, {6'h00, mms_pkg::CTRL_RESET});
    arst_n <= 1'b1;
    $display("test done mid-run reset");
    run(2'h2, 5'h00, 5'h10, 16'h0000, 1'b1, d);
    run(2'h1, 5'h07, 5'h10, e, 1'b0, 16'h0000);
    run(2'h2, 5'h07, 5'h10, 16'h0000, 1'b0, 16'hFFFF);
    run(2'h0, 5'h05, 5'h10, e, 1'b0, 16'h0000);
    run(2'h3, 5'h05, 5'h10, e, 1'b0, 16'h0000);
    run(2'h1, 5'h05, 5'h14, e, 1'b0, 16'h0000);
    run(2'h2, 5'h05, 5'h14, 16'h0000, 1'b1, 16'h0000);
    // A frozen core must let a whole write frame pass untouched
    clk_en <= 1'b0;
    run(2'h1, 5'h05, 5'h10, e, 1'b0, 16'h0000);
    clk_en <= 1'b1;
    run(2'h2, 5'h05, 5'h10, 16'h0000, 1'b1, d);
    chk({6'h00, off_ctrl}, {6'h00, cfg_vector});
    chk({21'h00_0000, off_seen}, 22'h00_0000);
    wrap_up();
  end
endmodule : mms_slave_tb_top
